/* File: tsw_status_exchange.sv */
`timescale 1ns/1ps
`include "tsw_consts.svh"

// Behaviour
// - Act only on control changes after startup
// - Bit 4 rising prints daily report once
// - Notify bit 15 set only in run
// - One host write reports the stop, then none while not running
// - Bit 12 strobes screen change until reported
// - Bit 11 strobes numeral entry until reported
// - Bit 9 after three failed passwords
// - Link addresses 0-199 map to 1000-1199
// - Notify word written on any change after startup, except once stop is reported
// - Bit 15 controls backlight, key relights
// - Bit 5 rising prints history once
module tsw_status_exchange (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            nrst,
  // Avalon-MM slave
  input  wire tsw_pkg::tsw_req_s bus_req,
  output tsw_pkg::tsw_rsp_s    bus_rsp,
  // Terminal status and events
  input  wire tsw_pkg::tsw_term_s term,
  // Terminal actions and host word write
  output tsw_pkg::tsw_act_s    act
);

  typedef struct packed {
    tsw_pkg::tsw_phase_e phase;
    logic [15:0]         control;
    logic [15:0]         seen;
    logic [15:0]         alloc;
    logic [15:0]         last_sent;
    logic [1:0]          pw_count;
    tsw_pkg::tsw_rsp_s   rsp;
    tsw_pkg::tsw_act_s   act;
  } tsw_state_s;

  tsw_state_s  state;
  tsw_state_s  next_state;
  logic        running;
  logic        flag_screen;
  logic        flag_numeral;
  logic        flag_pwerr;
  logic        pw_trip;
  logic [15:0] notify;
  logic [15:0] changed;
  logic [13:0] mapped;
  logic        clear_screen;
  logic        clear_numeral;
  logic        clear_pwerr;

  // ----------------------------------------
  // Status word and event flags
  // ----------------------------------------
  assign running = term.run_mode & ~term.menu_shown;
  assign pw_trip = term.password_fail && (state.pw_count == `TSW_PW_TRIES - 2'h1);

  // Only strobes carried by the last write are cleared, so an event at the write edge survives
  assign clear_screen  = state.act.notify_write & state.act.notify_data[`TSW_NTF_SCREEN];
  assign clear_numeral = state.act.notify_write & state.act.notify_data[`TSW_NTF_NUMERAL];
  assign clear_pwerr   = state.act.notify_write & state.act.notify_data[`TSW_NTF_PWERR];

  tsw_event_flag u_screen (
    .clock (clock),
    .nrst  (nrst),
    .set   (term.screen_changed),
    .clear (clear_screen),
    .flag  (flag_screen)
  );

  tsw_event_flag u_numeral (
    .clock (clock),
    .nrst  (nrst),
    .set   (term.numeral_entered),
    .clear (clear_numeral),
    .flag  (flag_numeral)
  );

  tsw_event_flag u_pwerr (
    .clock (clock),
    .nrst  (nrst),
    .set   (pw_trip),
    .clear (clear_pwerr),
    .flag  (flag_pwerr)
  );

  always_comb begin
    notify                 = `TSW_RST_WORD;
    notify[`TSW_NTF_RUN]     = running;
    notify[`TSW_NTF_SCREEN]  = flag_screen;
    notify[`TSW_NTF_NUMERAL] = flag_numeral;
    notify[`TSW_NTF_PWERR]   = flag_pwerr;
  end

  // ----------------------------------------
  // Host word address remap
  // ----------------------------------------
  always_comb begin
    mapped = state.alloc[13:0];
    if (state.alloc[`TSW_ALLOC_LINK] && state.alloc[13:0] <= `TSW_LINK_LAST) begin
      mapped = state.alloc[13:0] + `TSW_CORE_BASE;
    end
  end

  assign changed = state.control & ~state.seen & `TSW_CTL_USED;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state                   = state;
    next_state.act.print_daily   = 1'b0;
    next_state.act.print_history = 1'b0;
    next_state.act.notify_write  = 1'b0;
    next_state.rsp.waitrequest   = 1'b1;
    next_state.act.notify_addr   = mapped;

    // Avalon slave: one wait cycle, then the access completes
    if ((bus_req.read || bus_req.write) && state.rsp.waitrequest) begin
      next_state.rsp.waitrequest = 1'b0;
      case (bus_req.address)
        `TSW_OFS_CONTROL: begin
          next_state.rsp.readdata = {16'h0000, state.control};
        end
        `TSW_OFS_NOTIFY: begin
          next_state.rsp.readdata = {16'h0000, notify};
        end
        `TSW_OFS_ALLOC: begin
          next_state.rsp.readdata = {16'h0000, state.alloc};
        end
        `TSW_OFS_MAPPED: begin
          next_state.rsp.readdata = {18'h00000, mapped};
        end
        default: begin
          next_state.rsp.readdata = 32'h00000000;
        end
      endcase
    end
    if (bus_req.write && !state.rsp.waitrequest) begin
      case (bus_req.address)
        `TSW_OFS_CONTROL: begin
          next_state.control = bus_req.writedata[15:0];
        end
        `TSW_OFS_ALLOC: begin
          next_state.alloc = bus_req.writedata[15:0];
        end
        default: begin
        end
      endcase
    end

    // Password failure run count
    if (term.password_ok) begin
      next_state.pw_count = 2'h0;
    end else if (term.password_fail) begin
      next_state.pw_count = pw_trip ? 2'h0 : state.pw_count + 2'h1;
    end

    // Control word edge handling
    case (state.phase)
      tsw_pkg::TSW_IDLE: begin
        next_state.seen = state.control;
        if (term.started) begin
          next_state.phase = tsw_pkg::TSW_STARTED;
        end
      end
      tsw_pkg::TSW_STARTED: begin
        if (running) begin
          next_state.seen = state.control;
          if (changed[`TSW_CTL_DAILY]) begin
            next_state.act.print_daily = 1'b1;
          end
          if (changed[`TSW_CTL_HISTORY]) begin
            next_state.act.print_history = 1'b1;
          end
          if (changed[`TSW_CTL_SCREEN]) begin
            next_state.act.backlight_on = 1'b1;
          end else if (state.seen[`TSW_CTL_SCREEN] && !state.control[`TSW_CTL_SCREEN]) begin
            next_state.act.backlight_on = 1'b0;
          end
        end
        if (notify != state.last_sent && !state.act.notify_write && term.started &&
            (running || state.last_sent[`TSW_NTF_RUN])) begin
          next_state.act.notify_write = 1'b1;
          next_state.act.notify_data  = notify;
          next_state.last_sent        = notify;
        end
      end
      default: begin
        next_state.phase = tsw_pkg::TSW_IDLE;
      end
    endcase
    if (term.key_pressed) begin
      next_state.act.backlight_on = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state                  <= '0;
      state.phase            <= tsw_pkg::TSW_IDLE;
      state.control          <= `TSW_RST_CONTROL;
      state.seen             <= `TSW_RST_CONTROL;
      state.rsp.waitrequest  <= 1'b1;
      state.act.backlight_on <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign bus_rsp = state.rsp;
  assign act     = state.act;

endmodule

/* File: tsw_consts.svh */
`ifndef TSW_CONSTS_SVH
`define TSW_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TSW_OFS_CONTROL   4'h0
`define TSW_OFS_NOTIFY    4'h4
`define TSW_OFS_ALLOC     4'h8
`define TSW_OFS_MAPPED    4'hC

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define TSW_CTL_DAILY     4
`define TSW_CTL_HISTORY   5
`define TSW_CTL_SCREEN    15
`define TSW_CTL_USED      16'h8030

// ----------------------------------------
// Notify word fields
// ----------------------------------------
`define TSW_NTF_PWERR     9
`define TSW_NTF_NUMERAL   11
`define TSW_NTF_SCREEN    12
`define TSW_NTF_RUN       15

// ----------------------------------------
// Allocation word fields and area remap
// ----------------------------------------
`define TSW_ALLOC_LINK    15
`define TSW_LINK_LAST     14'h00C7
`define TSW_CORE_BASE     14'h03E8

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define TSW_RST_CONTROL   16'h8000
`define TSW_RST_WORD      16'h0000
`define TSW_PW_TRIES      2'h3

`endif

/* File: tsw_pkg.sv */
package tsw_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } tsw_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } tsw_rsp_s;

  typedef struct packed {
    logic run_mode;
    logic menu_shown;
    logic started;
    logic screen_changed;
    logic numeral_entered;
    logic password_fail;
    logic password_ok;
    logic key_pressed;
  } tsw_term_s;

  typedef struct packed {
    logic        backlight_on;
    logic        print_daily;
    logic        print_history;
    logic        notify_write;
    logic [15:0] notify_data;
    logic [13:0] notify_addr;
  } tsw_act_s;

  typedef enum logic [1:0] {
    TSW_IDLE,
    TSW_STARTED
  } tsw_phase_e;

endpackage

/* File: tsw_event_flag.sv */
`timescale 1ns/1ps

module tsw_event_flag (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Event and report
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } tsw_flag_s;

  tsw_flag_s state;
  tsw_flag_s next_state;

  // ----------------------------------------
  // Sticky flag, set wins over clear
  // ----------------------------------------
  always_comb begin
    next_state = state;
    if (set) begin
      next_state.flag = 1'b1;
    end else if (clear) begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;

endmodule

/* File: tsw_host_model.sv */
`timescale 1ns/1ps
module tsw_host_model (
  // Clock and reset
  input wire logic              clock,
  input wire logic              nrst,
  // Terminal side
  input wire tsw_pkg::tsw_act_s act,
  // Host memory
  output logic [15:0]           word,
  output logic [13:0]           addr,
  output int                    writes
);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      word <= 16'h0000;
      addr <= 14'h0000;
      writes <= 0;
    end else if (act.notify_write) begin
      word <= act.notify_data;
      addr <= act.notify_addr;
      writes <= writes + 1;
    end
  end
endmodule

/* File: tsw_status_exchange_assertions.sv */
`timescale 1ns/1ps
module tsw_checker (
  // Clock and reset
  input wire logic               clock,
  input wire logic               nrst,
  // Watched ports
  input wire tsw_pkg::tsw_req_s  bus_req,
  input wire tsw_pkg::tsw_rsp_s  bus_rsp,
  input wire tsw_pkg::tsw_term_s term,
  input wire tsw_pkg::tsw_act_s  act
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic stop_sent;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst) stop_sent <= 1'b1;
    else if (act.notify_write) stop_sent <= !act.notify_data[15];
  a_wait_one: assert property ((bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
    else $error("late answer");
  a_wait_short: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
    else $error("long answer");
  a_daily_once: assert property (act.print_daily |=> !act.print_daily)
    else $error("daily twice");
  a_hist_once: assert property (act.print_history |=> !act.print_history)
    else $error("history twice");
  a_key_light: assert property (term.key_pressed |=> act.backlight_on)
    else $error("key no light");
  a_ntf_undef: assert property (act.notify_write |-> (act.notify_data & 16'h65FF) == 16'h0000)
    else $error("undefined bit set");
  a_ntf_gap: assert property (act.notify_write |=> !act.notify_write)
    else $error("notify back to back");
  a_stop_quiet: assert property (stop_sent && act.notify_write |-> act.notify_data[15])
    else $error("write while stopped");
  c_daily: cover property (act.print_daily);
  c_hist: cover property (act.print_history);
  c_pw: cover property (act.notify_write && act.notify_data[9]);
endmodule
bind tsw_status_exchange tsw_checker i_tsw_checker (.clock(clock), .nrst(nrst), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .term(term), .act(act));

/* File: tb_tsw_status_exchange.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_tsw_status_exchange;
  logic               clock = 1'b0;
  logic               nrst = 1'b0;
  tsw_pkg::tsw_req_s  bus_req = '0;
  tsw_pkg::tsw_rsp_s  bus_rsp;
  tsw_pkg::tsw_term_s term = '0;
  tsw_pkg::tsw_act_s  act;
  logic [15:0]        hword;
  logic [13:0]        haddr;
  logic [31:0]        rd;
  int                 hwrites;
  int                 w0 = 0;
  int                 fails = 0;
  int                 checks = 0;
  int                 cyc = 0;
  int                 n_daily = 0;
  int                 n_hist = 0;
  tsw_status_exchange i_tsw_status_exchange (.clock(clock), .nrst(nrst), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .term(term), .act(act));
  tsw_host_model i_tsw_host_model (.clock(clock), .nrst(nrst), .act(act), .word(hword), .addr(haddr),
    .writes(hwrites));
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    n_daily <= n_daily + (act.print_daily === 1'b1);
    n_hist <= n_hist + (act.print_history === 1'b1);
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_req.read <= !w;
    bus_req.write <= w;
    bus_req.address <= a;
    bus_req.writedata <= {16'h0000, d};
    do @(posedge clock); while (bus_rsp.waitrequest !== 1'b0);
    rd = bus_rsp.readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
  endtask
  task automatic ev(input int b, input int n);
    @(posedge clock);
    term[b] <= 1'b1;
    repeat (n) @(posedge clock);
    term[b] <= 1'b0;
  endtask
  task automatic await_w(input logic [15:0] e);
    int k = 0;
    while (hwrites == w0 && k < 20) begin
      @(posedge clock);
      k++;
    end
    `CHK("host write", 1'b1, hwrites != w0)
    `CHK("host word", e, hword)
    w0 = hwrites;
  endtask
  task automatic t_regs;
    logic [3:0] ra [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    logic [15:0] al [4] = '{16'h80C8, 16'h00C7, 16'h8000, 16'h80C7};
    logic [31:0] mp [4] = '{32'h000000C8, 32'h000000C7, 32'h000003E8, 32'h000004AF};
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, ra[i], 16'h0000);
      `CHK("reset read", (i == 0) ? 32'h00008000 : 32'h00000000, rd)
    end
    acc(1'b1, 4'h4, 16'hFFFF);
    acc(1'b0, 4'h4, 16'h0000);
    `CHK("notify ro", 32'h00000000, rd)
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 4'h8, al[i]);
      acc(1'b0, 4'hC, 16'h0000);
      `CHK("mapped", mp[i], rd)
    end
    $display("t_regs done");
  endtask
  task automatic t_ctl;
    acc(1'b1, 4'h0, 16'h8010);
    term.started <= 1'b1;
    term.run_mode <= 1'b1;
    await_w(16'h8000);
    `CHK("daily early", 0, n_daily)
    acc(1'b1, 4'h0, 16'h8000);
    acc(1'b1, 4'h0, 16'h8010);
    acc(1'b1, 4'h0, 16'h8011);
    acc(1'b1, 4'h0, 16'h8031);
    idle(3);
    `CHK("daily", 1, n_daily)
    `CHK("history", 1, n_hist)
    acc(1'b1, 4'h0, 16'h0031);
    idle(3);
    `CHK("light off", 1'b0, act.backlight_on)
    ev(0, 1);
    idle(2);
    `CHK("light key", 1'b1, act.backlight_on)
    acc(1'b1, 4'h0, 16'h8031);
    acc(1'b1, 4'h0, 16'h0031);
    idle(3);
    `CHK("light off again", 1'b0, act.backlight_on)
    acc(1'b1, 4'h0, 16'h8031);
    idle(3);
    `CHK("light bit", 1'b1, act.backlight_on)
    $display("t_ctl done");
  endtask
  task automatic t_ntf;
    ev(4, 2);
    await_w(16'h9000);
    await_w(16'h8000);
    ev(3, 1);
    await_w(16'h8800);
    await_w(16'h8000);
    `CHK("host addr", 14'h04AF, haddr)
    ev(2, 1);
    ev(2, 1);
    ev(1, 1);
    ev(2, 1);
    ev(2, 1);
    idle(6);
    `CHK("no pw report", w0, hwrites)
    ev(2, 1);
    await_w(16'h8200);
    await_w(16'h8000);
    $display("t_ntf done");
  endtask
  task automatic t_stop;
    acc(1'b0, 4'h4, 16'h0000);
    `CHK("run poll", 32'h00008000, rd)
    term.menu_shown <= 1'b1;
    await_w(16'h0000);
    acc(1'b0, 4'h4, 16'h0000);
    `CHK("stop poll", 32'h00000000, rd)
    ev(4, 1);
    idle(6);
    `CHK("quiet", w0, hwrites)
    term.menu_shown <= 1'b0;
    idle(12);
    `CHK("resumed", 16'h8000, hword)
    term.run_mode <= 1'b0;
    w0 = hwrites;
    await_w(16'h0000);
    $display("t_stop done");
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    idle(2);
    nrst <= 1'b1;
    t_regs();
    t_ctl();
    t_ntf();
    t_stop();
    conclude();
  end
endmodule
